// ---- basd_decode.sv ----
/*
 * bus address and strobe decode: physical address forming, port
 * addressing, upper memory select, upper-zero flag, write strobes and
 * the pin isolation mode caught at reset release.
 * assumes requests synchronous to clock, one bus cycle per request,
 * each cycle holding for cycle_len clocks; pads resolve the enables.
 */

// What this block does
// R1: physical address is segment shifted four plus offset
// R2: segment implied by reference kind
// R3: ports addressed by 8-bit immediate or pointer
// R4: 8-bit port zero extended, A15-A8 low
// R5: ports 00F8h-00FFh reserved, not for outside use
// R6: upper select asserted inside programmable block
// R7: after reset upper block is F0000h-FFFFFh
// R8: bank1 row strobe enable kills upper select
// R9: bank1 enabling code must not run upper
// R10: bus hold floats upper select, weakly high
// R11: both isolation pins low at release floats all
// R12: upper-zero flag is NOR of A19-A16
// R13: high write strobe is enable OR write
// R14: low write strobe is A0 OR write
// R15: write strobe asserted on writes, floats hold/reset
module basd_decode #(
	parameter int CYCLE_LEN = 4               // clocks per bus cycle
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire basd_pkg::basd_req_t  req,
	input  wire basd_pkg::basd_segs_t segs,
	input  wire logic [19:0]          ums_base,        // programmed base
	input  wire logic [19:0]          ums_size,        // programmed size
	input  wire logic                 ums_program,     // load base/size
	input  wire logic                 dram_row_strobe_bank1_en,
	input  wire logic                 bus_hold,
	input  wire logic                 isolation_request_0,
	input  wire logic                 isolation_request_1,
	output logic                      busy,
	output logic [19:0]               addr_out,
	output logic                      addr_oe,
	output logic                      io_cycle,
	output logic                      upper_memory_select_n,
	output logic                      upper_memory_select_oe,
	output logic                      upper_memory_select_pull,
	output logic                      upper_zero_flag,
	output logic                      upper_zero_flag_oe,
	output logic                      write_strobe_n,
	output logic                      write_strobe_oe,
	output logic                      high_byte_write_strobe_n,
	output logic                      low_byte_write_strobe_n,
	output logic                      byte_strobe_oe,
	output logic                      high_byte_enable_n,
	output logic                      isolated
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------

	// segment and offset into a 20-bit physical address
	function automatic logic [19:0] phys_addr(input logic [15:0] seg,
		input logic [15:0] off);
	begin
		phys_addr = {seg, 4'h0} + {4'h0, off}; // R1
	end
	endfunction : phys_addr

	// implicit segment per reference kind
	function automatic basd_pkg::basd_seg_t seg_pick(
		input basd_pkg::basd_ref_t kind);
	begin
		case (kind) // R2
			basd_pkg::BASD_REF_FETCH:  seg_pick = basd_pkg::BASD_SEG_CODE;
			basd_pkg::BASD_REF_STACK,
			basd_pkg::BASD_REF_BP:     seg_pick = basd_pkg::BASD_SEG_STACK;
			basd_pkg::BASD_REF_STRDI:  seg_pick = basd_pkg::BASD_SEG_EXTRA;
			default:                   seg_pick = basd_pkg::BASD_SEG_DATA;
		endcase
	end
	endfunction : seg_pick

	// ---------------------------------------------------------------
	// bus cycle sequencing
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		BASD_ST_IDLE = 2'b00,     // no cycle in progress
		BASD_ST_RUN  = 2'b01      // address and strobes held
	} basd_state_t;

	basd_state_t       state_reg;        // cycle state
	logic [7:0]        cnt_reg;          // clocks left in the cycle
	logic [19:0]       base_reg;         // upper block base
	logic [19:0]       size_reg;         // upper block size
	logic              ums_dead_reg;     // upper select retired
	logic              iso_reg;          // pins isolated until reset
	logic              iso_armed_reg;    // first clock after release
	logic [15:0]       seg_val;          // chosen segment value
	logic [19:0]       addr_next;        // address for a new cycle
	logic              io_next;          // new cycle is i/o
	logic              hit_next;         // new cycle inside upper block
	logic              float_all;        // isolation or hold floats pins
	logic              start;            // a request is accepted

	assign start = req.valid && (state_reg == BASD_ST_IDLE) && !bus_hold
		&& !iso_reg;
	assign float_all = iso_reg || bus_hold;

	// choose the segment value from the implied register
	always_comb
	begin
		case (seg_pick(req.kind))
			basd_pkg::BASD_SEG_CODE:  seg_val = segs.code_seg;
			basd_pkg::BASD_SEG_STACK: seg_val = segs.stack_seg;
			basd_pkg::BASD_SEG_EXTRA: seg_val = segs.extra_segment_reg;
			default:                  seg_val = segs.data_segment_reg;
		endcase
	end

	// form the address: memory via segments, i/o via port numbers.
	// the reserved port window is not filtered; keeping out is on sw.
	always_comb
	begin
		io_next = 1'b0;
		if (req.kind == basd_pkg::BASD_REF_IO8)
		begin
			io_next = 1'b1;
			addr_next = {12'h000, req.offset[7:0]}; // R3 R4
		end
		else if (req.kind == basd_pkg::BASD_REF_IO16)
		begin
			io_next = 1'b1;
			addr_next = {4'h0, segs.port_pointer_reg}; // R3
		end
		else
		begin
			addr_next = phys_addr(seg_val, req.offset); // R1
		end
	end

	// upper block hit; size capped at 512 Kbyte
	always_comb
	begin
		hit_next = !io_next && (addr_next >= base_reg)
			&& ((addr_next - base_reg) < size_reg); // R6
	end

	// ---------------------------------------------------------------
	// state and cycle counter
	// ---------------------------------------------------------------
	// each cycle holds for CYCLE_LEN clocks then returns to idle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= BASD_ST_IDLE;
			cnt_reg   <= 8'h00;
		end
		else
		begin
			case (state_reg)
				BASD_ST_IDLE:
				begin
					if (start)
					begin
						state_reg <= BASD_ST_RUN;
						cnt_reg   <= 8'(CYCLE_LEN - 1);
					end
				end
				default:
				begin
					if (cnt_reg == 8'h00)
						state_reg <= BASD_ST_IDLE;
					else
						cnt_reg <= cnt_reg - 8'h01;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// upper block window and retirement
	// ---------------------------------------------------------------
	// defaults cover the reset fetch address
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			base_reg <= basd_pkg::UMS_BASE_RST; // R7
			size_reg <= basd_pkg::UMS_SIZE_RST; // R7
		end
		else if (ums_program)
		begin
			base_reg <= ums_base;
			// oversize requests clip to the cap
			size_reg <= (ums_size > basd_pkg::UMS_SIZE_MAX) ?
				basd_pkg::UMS_SIZE_MAX : ums_size; // R6
		end
	end

	// once bank1 is on, the upper select never comes back until reset.
	// code running from the upper block loses its memory here.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ums_dead_reg <= 1'b0;
		else if (dram_row_strobe_bank1_en)
			ums_dead_reg <= 1'b1; // R8 R9
	end

	// ---------------------------------------------------------------
	// isolation mode capture
	// ---------------------------------------------------------------
	// sampled on the first clock after release, since an async reset
	// may only load constants; held until the next reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			iso_armed_reg <= 1'b1;
			iso_reg       <= 1'b0;
		end
		else if (iso_armed_reg)
		begin
			iso_armed_reg <= 1'b0;
			iso_reg <= !isolation_request_0 && !isolation_request_1; // R11
		end
	end

	// ---------------------------------------------------------------
	// address, flag and strobe outputs
	// ---------------------------------------------------------------
	// latched at the first period and held through the cycle, except the select, which a bank1 enable drops early
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_out                 <= 20'h00000;
			io_cycle                 <= 1'b0;
			upper_memory_select_n    <= 1'b1;
			upper_zero_flag          <= 1'b0;
			write_strobe_n           <= 1'b1;
			high_byte_write_strobe_n <= 1'b1;
			low_byte_write_strobe_n  <= 1'b1;
			high_byte_enable_n       <= 1'b1;
		end
		else if (start)
		begin
			addr_out <= addr_next;
			io_cycle <= io_next;
			upper_memory_select_n <= !(hit_next && !ums_dead_reg
				&& !dram_row_strobe_bank1_en); // R6 R8
			upper_zero_flag <= ~|addr_next[19:16]; // R12
			write_strobe_n <= !req.write; // R15
			high_byte_enable_n <= !req.byte_hi;
			// active-low OR of enable and write strobe
			high_byte_write_strobe_n <= !req.byte_hi || !req.write; // R13
			// low lane follows address bit zero
			low_byte_write_strobe_n <= addr_next[0] || !req.write; // R14
		end
		else if (state_reg == BASD_ST_RUN && cnt_reg == 8'h00)
		begin
			// cycle ends: release selects and strobes, keep address
			upper_memory_select_n    <= 1'b1;
			write_strobe_n           <= 1'b1;
			high_byte_write_strobe_n <= 1'b1;
			low_byte_write_strobe_n  <= 1'b1;
			high_byte_enable_n       <= 1'b1;
		end
		// the enable edge itself negates, so a running cycle loses its
		// select at once instead of one clock late
		else if (ums_dead_reg || dram_row_strobe_bank1_en)
			upper_memory_select_n <= 1'b1; // R8
	end

	// ---------------------------------------------------------------
	// output enables
	// ---------------------------------------------------------------
	// reset holds every enable low, so strobes float during reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_oe                  <= 1'b0;
			upper_memory_select_oe   <= 1'b0;
			upper_memory_select_pull <= 1'b1;
			upper_zero_flag_oe       <= 1'b0;
			write_strobe_oe          <= 1'b0; // R15
			byte_strobe_oe           <= 1'b0; // R13 R14
			isolated                 <= 1'b0;
			busy                     <= 1'b0;
		end
		else
		begin
			addr_oe <= !float_all && !iso_armed_reg;
			upper_memory_select_oe <= !float_all && !iso_armed_reg; // R10
			// weak pullup in hold; none when isolated
			upper_memory_select_pull <= bus_hold && !iso_reg; // R10
			upper_zero_flag_oe <= !iso_reg && !iso_armed_reg; // R11
			write_strobe_oe <= !float_all && !iso_armed_reg; // R15
			byte_strobe_oe <= !iso_reg && !iso_armed_reg; // R11
			isolated <= iso_reg;
			busy <= start || (state_reg == BASD_ST_RUN && cnt_reg != 8'h00);
		end
	end

endmodule : basd_decode

// ---- basd_decode_properties.sv ----
/* port relations of the decode block, bound onto basd_decode.
   assumes one clock domain and an active-low async reset. */
module basd_decode_props #(
	parameter int CYCLE_LEN = 4
) (
	input wire logic		clock,
	input wire logic		rst_n,
	input wire logic		dram_row_strobe_bank1_en,
	input wire logic		bus_hold,
	input wire logic		busy,
	input wire logic [19:0]	addr_out,
	input wire logic		addr_oe,
	input wire logic		io_cycle,
	input wire logic		upper_memory_select_n,
	input wire logic		upper_memory_select_oe,
	input wire logic		upper_memory_select_pull,
	input wire logic		upper_zero_flag,
	input wire logic		upper_zero_flag_oe,
	input wire logic		write_strobe_n,
	input wire logic		write_strobe_oe,
	input wire logic		high_byte_write_strobe_n,
	input wire logic		low_byte_write_strobe_n,
	input wire logic		byte_strobe_oe,
	input wire logic		high_byte_enable_n,
	input wire logic		isolated
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// -------------------------------------------------------------
	// helper logic
	// -------------------------------------------------------------
	logic		bank1_seen_reg;	// bank1 enabled since reset
	logic [7:0]	wr_low_reg;	// cycles the write strobe sat low
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			bank1_seen_reg <= 1'b0;
		else if (dram_row_strobe_bank1_en)
			bank1_seen_reg <= 1'b1;
	end
	// counts in a byte: a stuck strobe shows long before wrap
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wr_low_reg <= 8'h00;
		else
			wr_low_reg <= write_strobe_n ? 8'h00 : wr_low_reg + 8'h01;
	end
	// -------------------------------------------------------------
	// cycle steps
	// -------------------------------------------------------------
	sequence s_cycle_open;
		$rose(busy);
	endsequence
	sequence s_flag_held;
		(upper_zero_flag == (addr_out[19:16] == 4'h0)) ##1
			$stable(upper_zero_flag);
	endsequence
	AST_UZF: assert property (s_cycle_open |-> s_flag_held)
		else $error("upper zero flag wrong or not held");
	AST_WLB: assert property (!low_byte_write_strobe_n |->
		!write_strobe_n && !addr_out[0])
		else $error("low byte strobe without write on even address");
	AST_WHB: assert property (!high_byte_write_strobe_n |->
		!write_strobe_n && !high_byte_enable_n)
		else $error("high byte strobe without write and enable");
	AST_IO_ADDR: assert property (busy && io_cycle |->
		addr_out[19:16] == 4'h0)
		else $error("port cycle above 64K");
	AST_HOLD_FLOAT: assert property (bus_hold |=> !upper_memory_select_oe
		&& upper_memory_select_pull && !write_strobe_oe)
		else $error("hold left select or write driven");
	AST_BANK1: assert property (bank1_seen_reg |-> upper_memory_select_n)
		else $error("upper select after bank1 enable");
	AST_ISOLATED: assert property (isolated |-> !addr_oe
		&& !upper_memory_select_oe && !write_strobe_oe
		&& !byte_strobe_oe && !upper_zero_flag_oe)
		else $error("pin driven while isolated");
	AST_ISO_STICKY: assert property (isolated |=> isolated)
		else $error("isolation left before reset");
	AST_WR_SPAN: assert property (wr_low_reg <= CYCLE_LEN)
		else $error("write strobe longer than a cycle");
endmodule : basd_decode_props

bind basd_decode basd_decode_props #(.CYCLE_LEN(CYCLE_LEN)) props_i (
	.clock(clock), .rst_n(rst_n),
	.dram_row_strobe_bank1_en(dram_row_strobe_bank1_en),
	.bus_hold(bus_hold), .busy(busy), .addr_out(addr_out),
	.addr_oe(addr_oe), .io_cycle(io_cycle),
	.upper_memory_select_n(upper_memory_select_n),
	.upper_memory_select_oe(upper_memory_select_oe),
	.upper_memory_select_pull(upper_memory_select_pull),
	.upper_zero_flag(upper_zero_flag),
	.upper_zero_flag_oe(upper_zero_flag_oe),
	.write_strobe_n(write_strobe_n), .write_strobe_oe(write_strobe_oe),
	.high_byte_write_strobe_n(high_byte_write_strobe_n),
	.low_byte_write_strobe_n(low_byte_write_strobe_n),
	.byte_strobe_oe(byte_strobe_oe),
	.high_byte_enable_n(high_byte_enable_n), .isolated(isolated));

// ---- basd_far_model.sv ----
/* far side pins: resolves select and write wires from the enables.
   assumes the decode outputs feed it straight, no board pull on write. */
module basd_far_model (
	input wire logic	clock,
	input wire logic	rst_n,
	input wire logic	sel_n,
	input wire logic	sel_oe,
	input wire logic	sel_pull,
	input wire logic	wr_n,
	input wire logic	wr_oe,
	output logic		sel_pin,
	output logic		wr_pin
);
	logic	sel_last_reg;	// last driven select level
	logic	wr_last_reg;	// last driven write level
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_last_reg <= 1'b1;
			wr_last_reg <= 1'b1;
		end
		else
		begin
			if (sel_oe) sel_last_reg <= sel_n;
			if (wr_oe) wr_last_reg <= wr_n;
		end
	end
	// undriven wire without pull shows the inverse so a stale value cannot pass
	always_comb
		sel_pin = sel_oe ? sel_n : (sel_pull ? 1'b1 : ~sel_last_reg);
	always_comb
		wr_pin = wr_oe ? wr_n : ~wr_last_reg;
endmodule : basd_far_model

// ---- basd_pkg.sv ----
/*
 * shared constants and carrier types for the bus address and strobe
 * decode block.
 * assumes a single 20 MHz clock domain and an active-low async reset.
 */
package basd_pkg;

	// ---------------------------------------------------------------
	// address geometry
	// ---------------------------------------------------------------
	localparam int SEG_SHIFT      = 4;        // segment shifted left by 4
	localparam int PHYS_W         = 20;       // 1 Mbyte physical space
	localparam int WORD_W         = 16;       // segment, offset, port width
	localparam int SHORT_PORT_W   = 8;        // port number in instruction

	// ---------------------------------------------------------------
	// upper memory select after reset: F0000h..FFFFFh (64 Kbyte)
	// ---------------------------------------------------------------
	localparam logic [19:0] UMS_BASE_RST = 20'hF0000;
	localparam logic [19:0] UMS_SIZE_RST = 20'h10000;
	localparam logic [19:0] UMS_SIZE_MAX = 20'h80000; // 512 Kbyte cap

	// ---------------------------------------------------------------
	// reserved port window, kept out of use by software
	// ---------------------------------------------------------------
	localparam logic [15:0] RSV_PORT_LO  = 16'h00F8;
	localparam logic [15:0] RSV_PORT_HI  = 16'h00FF;

	// ---------------------------------------------------------------
	// segment choice and access kinds
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		BASD_SEG_CODE  = 2'b00,
		BASD_SEG_DATA  = 2'b01,
		BASD_SEG_STACK = 2'b10,
		BASD_SEG_EXTRA = 2'b11
	} basd_seg_t;

	typedef enum logic [2:0] {
		BASD_REF_FETCH  = 3'b000, // instruction fetch
		BASD_REF_DATA   = 3'b001, // ordinary data
		BASD_REF_STACK  = 3'b010, // push or pop
		BASD_REF_BP     = 3'b011, // base pointer addressed
		BASD_REF_STRDI  = 3'b100, // string ref indexed by dest index
		BASD_REF_IO8    = 3'b101, // port number in instruction
		BASD_REF_IO16   = 3'b110  // port number in port pointer
	} basd_ref_t;

	// one bus request from the execution side
	typedef struct packed {
		logic             valid;     // start a bus cycle
		basd_ref_t        kind;      // reference kind
		logic             write;     // write cycle
		logic             byte_hi;   // high byte lane takes part
		logic             byte_lo;   // low byte lane takes part
		logic [15:0]      offset;    // offset or 8-bit port in [7:0]
	} basd_req_t;

	// segment register file contents
	typedef struct packed {
		logic [15:0] code_seg;
		logic [15:0] data_segment_reg;
		logic [15:0] stack_seg;
		logic [15:0] extra_segment_reg;
		logic [15:0] port_pointer_reg;
	} basd_segs_t;

endpackage : basd_pkg

// ---- test_bus_address_strobe_decode.sv ----
/* self-checking bench for basd_decode with the far side model.
   assumes the package is compiled first and inputs change at negedge. */
module test_bus_address_strobe_decode;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CYCLE_LEN = 3;	// short cycles keep the run brief
	typedef struct packed {
		basd_pkg::basd_ref_t	kind;
		logic			w;
		logic			hi;
		logic [15:0]		off;
		logic [19:0]		ea;
	} basd_row_t;
	logic clock, rst_n, ums_program, dram_row_strobe_bank1_en, bus_hold;
	logic isolation_request_0, isolation_request_1, busy, addr_oe, io_cycle;
	logic upper_memory_select_n, upper_memory_select_oe;
	logic upper_memory_select_pull, upper_zero_flag, upper_zero_flag_oe;
	logic write_strobe_n, write_strobe_oe, high_byte_write_strobe_n;
	logic low_byte_write_strobe_n, byte_strobe_oe, high_byte_enable_n;
	logic isolated, sel_pin, wr_pin, bank1_seen;
	logic [19:0] addr_out, ums_base, ums_size, ub, us;
	basd_pkg::basd_req_t	req;
	basd_pkg::basd_segs_t	segs;
	int mismatches, cmp_count, ticks;
	// segs: code F000, data 1000, stack 0001, extra EFFF, port ABCD
	basd_row_t rows [7] = '{
		'{basd_pkg::BASD_REF_FETCH, 1'b0, 1'b1, 16'hFFF0, 20'hFFFF0},
		'{basd_pkg::BASD_REF_DATA,  1'b1, 1'b1, 16'h0003, 20'h10003},
		'{basd_pkg::BASD_REF_STACK, 1'b1, 1'b0, 16'h0002, 20'h00012},
		'{basd_pkg::BASD_REF_BP,    1'b0, 1'b1, 16'hFFFF, 20'h1000F},
		'{basd_pkg::BASD_REF_STRDI, 1'b1, 1'b1, 16'h0010, 20'hF0000},
		'{basd_pkg::BASD_REF_IO8,   1'b1, 1'b1, 16'h12F7, 20'h000F7},
		'{basd_pkg::BASD_REF_IO16,  1'b0, 1'b1, 16'h0000, 20'h0ABCD}};
	basd_decode #(.CYCLE_LEN(CYCLE_LEN)) basd_decode_i (.clock(clock),
		.rst_n(rst_n), .req(req), .segs(segs), .ums_base(ums_base),
		.ums_size(ums_size), .ums_program(ums_program),
		.dram_row_strobe_bank1_en(dram_row_strobe_bank1_en),
		.bus_hold(bus_hold), .isolation_request_0(isolation_request_0),
		.isolation_request_1(isolation_request_1), .busy(busy),
		.addr_out(addr_out), .addr_oe(addr_oe), .io_cycle(io_cycle),
		.upper_memory_select_n(upper_memory_select_n),
		.upper_memory_select_oe(upper_memory_select_oe),
		.upper_memory_select_pull(upper_memory_select_pull),
		.upper_zero_flag(upper_zero_flag),
		.upper_zero_flag_oe(upper_zero_flag_oe),
		.write_strobe_n(write_strobe_n), .write_strobe_oe(write_strobe_oe),
		.high_byte_write_strobe_n(high_byte_write_strobe_n),
		.low_byte_write_strobe_n(low_byte_write_strobe_n),
		.byte_strobe_oe(byte_strobe_oe),
		.high_byte_enable_n(high_byte_enable_n), .isolated(isolated));
	basd_far_model basd_far_model_i (.clock(clock), .rst_n(rst_n),
		.sel_n(upper_memory_select_n), .sel_oe(upper_memory_select_oe),
		.sel_pull(upper_memory_select_pull), .wr_n(write_strobe_n),
		.wr_oe(write_strobe_oe), .sel_pin(sel_pin), .wr_pin(wr_pin));
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// hang guard: the whole run needs well under 600 cycles
	always @(posedge clock)
	begin
		ticks <= ticks + 1;
		if (ticks == 3000)
		begin
			mismatches++;
			final_report();
		end
	end
	task automatic check(input string nm, input logic [19:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic do_reset(input logic i0, i1);
		rst_n = 1'b0;
		isolation_request_0 = i0;
		isolation_request_1 = i1;
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
	endtask : do_reset
	// one bus cycle; expectations from the row and the tracked window
	task automatic run(input basd_row_t r);
		logic io, hit;
		int n;
		io = r.kind inside {basd_pkg::BASD_REF_IO8, basd_pkg::BASD_REF_IO16};
		hit = !io && !bank1_seen && r.ea >= ub && (r.ea - ub) < us;
		req = '{1'b1, r.kind, r.w, r.hi, 1'b1, r.off};
		@(negedge clock);
		req.valid = 1'b0;
		check("addr", addr_out, r.ea);
		check("io", io_cycle, io);
		check("ums", upper_memory_select_n, !hit);
		check("uzf", upper_zero_flag, r.ea[19:16] == 4'h0);
		check("wr", write_strobe_n, !r.w);
		check("whb", high_byte_write_strobe_n, !r.hi | !r.w);
		check("wlb", low_byte_write_strobe_n, r.ea[0] | !r.w);
		check("busy", busy, 1'b1);
		check("addr_oe", addr_oe, 1'b1);
		check("hbe", high_byte_enable_n, !r.hi);
		check("wr_pin", wr_pin, !r.w);
		// count the clocks the cycle stands, bounded against a hang
		n = 0;
		while (busy === 1'b1 && n < 10)
		begin
			@(negedge clock);
			n++;
		end
		check("span", 20'(n), 20'(CYCLE_LEN));
		check("wr_end", write_strobe_n, 1'b1);
		check("ums_end", upper_memory_select_n, 1'b1);
		check("uzf_kept", upper_zero_flag, r.ea[19:16] == 4'h0);
		repeat (2) @(negedge clock);
	endtask : run
	task automatic final_report();
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial
	begin
		{ticks, mismatches, cmp_count} = '0;
		{ums_program, dram_row_strobe_bank1_en, bus_hold, bank1_seen} = '0;
		rst_n = 1'b0;
		req = '0;
		segs = '{16'hF000, 16'h1000, 16'h0001, 16'hEFFF, 16'hABCD};
		{ums_base, ums_size} = {20'h10000, 20'h10000};
		ub = basd_pkg::UMS_BASE_RST;
		us = basd_pkg::UMS_SIZE_RST;
		#10;
		check("wr_oe_rst", write_strobe_oe, 1'b0);
		check("bs_oe_rst", byte_strobe_oe, 1'b0);
		do_reset(1'b1, 1'b1);
		check("iso_off", isolated, 1'b0);
		foreach (rows[i]) run(rows[i]);
		// programmed window moves the select off the boot block
		ums_program = 1'b1;
		@(negedge clock);
		ums_program = 1'b0;
		ub = 20'h10000;
		run(rows[1]);
		run(rows[0]);
		// oversize request clips to the 512 Kbyte cap
		ums_base = 20'h00000;
		ums_size = 20'hFFFFF;
		ums_program = 1'b1;
		@(negedge clock);
		ums_program = 1'b0;
		ub = 20'h00000;
		us = basd_pkg::UMS_SIZE_MAX;
		run(rows[0]);
		// hold floats select with a weak high, refuses requests
		bus_hold = 1'b1;
		req.valid = 1'b1;
		repeat (2) @(negedge clock);
		check("ums_oe", upper_memory_select_oe, 1'b0);
		check("ums_pin", sel_pin, 1'b1);
		check("wr_oe", write_strobe_oe, 1'b0);
		check("hold_busy", busy, 1'b0);
		req.valid = 1'b0;
		bus_hold = 1'b0;
		@(negedge clock);
		// no upper block fetch runs around the enable
		dram_row_strobe_bank1_en = 1'b1;
		bank1_seen = 1'b1;
		@(negedge clock);
		// a one-clock enable must still retire the select for good
		dram_row_strobe_bank1_en = 1'b0;
		run(rows[1]);
		bank1_seen = 1'b0;
		do_reset(1'b0, 1'b0);
		check("iso_on", isolated, 1'b1);
		check("iso_addr_oe", addr_oe, 1'b0);
		check("iso_ums_oe", upper_memory_select_oe, 1'b0);
		check("iso_bs_oe", byte_strobe_oe, 1'b0);
		// requests are refused while the pins float
		req.valid = 1'b1;
		@(negedge clock);
		check("iso_busy", busy, 1'b0);
		req.valid = 1'b0;
		do_reset(1'b0, 1'b1);
		check("iso_one", isolated, 1'b0);
		final_report();
	end
endmodule : test_bus_address_strobe_decode
